// >>> sim/nvsrs_host_model.sv
`timescale 1ns/10ps
module nvsrs_host_model
(
   input  wire logic             clock,
   input  wire logic             pinOut,
   input  wire logic             pinOe,
   output logic                  pinLevel,
   output logic                  cmdValid,
   output nvsrs_pkg::nvsrs_cmd_t cmdCode,
   output logic                  accessStart
);
   import nvsrs_pkg::*;
   logic driveLow = 1'b0;
   initial
   begin
      cmdValid = 1'b0;
      cmdCode = NVSRS_CMD_RECALL;
      accessStart = 1'b0;
   end
   // Pull-up on the pin; low when either side pulls it down
   assign pinLevel = !(driveLow || (pinOe && !pinOut));
   task automatic hw_store(input int cycles);
      @(negedge clock);
      driveLow = 1'b1;
      repeat (cycles) @(negedge clock);
      driveLow = 1'b0;
   endtask
   task automatic send_cmd(input nvsrs_cmd_t code);
      @(negedge clock);
      cmdValid = 1'b1;
      cmdCode = code;
      @(negedge clock);
      cmdValid = 1'b0;
      // Idle code left nonzero so a missing qualifier shows
      cmdCode = NVSRS_CMD_RECALL;
   endtask
   // caller picks the spacing, short on purpose
   task automatic access(input int gap);
      repeat (gap) @(negedge clock);
      accessStart = 1'b1;
      @(negedge clock);
      accessStart = 1'b0;
   endtask
endmodule

// >>> sim/tb_nvsrs_sequencer.sv
`timescale 1ns/10ps
module tb_nvsrs_sequencer;
   import nvsrs_pkg::*;
   localparam int ST_CYC = 20;
   localparam int RC_CYC = 10;
   localparam int LIMIT  = 4 * SOFT_SEQ_CYCLES + 15000;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic       lowVoltageTrip;
   logic       fastSerialClock;
   logic       arrayWriteReq;
   logic       arrayReadReq;
   logic       pinLevel, cmdValid, accessStart, arrayWriteEn, arrayReadEn, ioBlocked;
   logic       nvStoreActive, nvRecallActive, powerLossStoreEn, writeLatch, pinOut, pinOe, accessRisk;
   nvsrs_cmd_t cmdCode;
   nvsrs_cmd_t cmds[$] = '{NVSRS_CMD_NONE, NVSRS_CMD_STORE, NVSRS_CMD_RECALL, NVSRS_CMD_PLS_DIS, NVSRS_CMD_PLS_EN};
   int         fail_count = 0;
   int         num_checks = 0;
   int         lfsr = 32'h0000fc41;
   int         modelLatch = 0;
   int         plsModel = 1;

   always #12.5 clock = ~clock;

   nvsrs_sequencer #(.STORE_CYCLES_P(ST_CYC), .RECALL_CYCLES_P(RC_CYC)) dut
   (
      .clock(clock), .reset_n(reset_n), .hwStoreBusyPinInN(pinLevel), .lowVoltageTrip(lowVoltageTrip),
      .fastSerialClock(fastSerialClock), .cmdValid(cmdValid), .cmdCode(cmdCode), .accessStart(accessStart),
      .arrayWriteReq(arrayWriteReq), .arrayReadReq(arrayReadReq), .arrayWriteEn(arrayWriteEn),
      .arrayReadEn(arrayReadEn), .ioBlocked(ioBlocked), .nvStoreActive(nvStoreActive),
      .nvRecallActive(nvRecallActive), .powerLossStoreEn(powerLossStoreEn), .writeLatch(writeLatch),
      .hwStoreBusyPinOut(pinOut), .hwStoreBusyPinOe(pinOe), .accessRisk(accessRisk)
   );

   nvsrs_host_model host
   (
      .clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .accessStart(accessStart)
   );

   function automatic int next_rand(input int v);
      return v[0] ? ((v >> 1) ^ 32'h0000b400) : (v >> 1);
   endfunction

   task automatic check(input string what, input logic exp, input logic seen);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wait_idle(input int limit);
      int n = 0;
      while (ioBlocked !== 1'b0 && n < limit)
      begin
         @(negedge clock);
         n++;
      end
      check("idle in time", 1'b0, ioBlocked);
   endtask

   // Random requests; the model grants only when nothing blocks
   task automatic poke(input int n, input logic block);
      repeat (n)
      begin
         @(negedge clock);
         lfsr = next_rand(lfsr);
         arrayWriteReq = lfsr[0];
         arrayReadReq = lfsr[1];
         #1;
         check("write grant", arrayWriteReq & ~block, arrayWriteEn);
         check("read grant", arrayReadReq & ~block, arrayReadEn);
         if (arrayWriteReq && !block)
            modelLatch = 1;
      end
      @(negedge clock);
      arrayWriteReq = 1'b0;
      arrayReadReq = 1'b0;
      check("write latch", modelLatch[0], writeLatch);
   endtask

   initial
   begin
      #(LIMIT * 25);
      fail_count++;
      results();
   end

   initial
   begin
      lowVoltageTrip = 1'b0;
      fastSerialClock = 1'b0;
      arrayWriteReq = 1'b0;
      arrayReadReq = 1'b0;
      repeat (3) @(negedge clock);
      check("blocked in reset", 1'b1, ioBlocked);
      check("recall in reset", 1'b1, nvRecallActive);
      check("pls enable reset", 1'b1, powerLossStoreEn);
      reset_n = 1'b1;
      wait_idle(RC_CYC + 8);
      poke(30, 1'b0);
      lowVoltageTrip = 1'b1;
      repeat (4) @(negedge clock);
      check("power-loss store", modelLatch[0], nvStoreActive);
      poke(6, 1'b1);
      lowVoltageTrip = 1'b0;
      wait_idle(ST_CYC + 8);
      modelLatch = 0;
      check("latch cleared", 1'b0, writeLatch);
      lowVoltageTrip = 1'b1;
      repeat (5) @(negedge clock);
      check("skipped store", 1'b0, nvStoreActive);
      lowVoltageTrip = 1'b0;
      repeat (4) @(negedge clock);
      fork
         host.hw_store(10);
         begin
            repeat (4) @(negedge clock);
            poke(5, 1'b1);
         end
      join
      check("pin store skipped", 1'b0, nvStoreActive);
      repeat (4) @(negedge clock);
      poke(30, 1'b0);
      host.hw_store(2);
      repeat (4) @(negedge clock);
      check("pin store", modelLatch[0], nvStoreActive);
      check("pin driven", modelLatch[0], pinOe);
      check("pin level", ~modelLatch[0], pinLevel);
      wait_idle(ST_CYC + 8);
      modelLatch = 0;
      fastSerialClock = 1'b1;
      host.access(0);
      host.access(3000);
      check("risky gap", 1'b1, accessRisk);
      host.access(100);
      check("short gap", 1'b0, accessRisk);
      fastSerialClock = 1'b0;
      host.access(3000);
      check("slow clock", 1'b0, accessRisk);
      poke(30, 1'b0);
      foreach (cmds[i])
      begin
         host.send_cmd(cmds[i]);
         repeat (2) @(negedge clock);
         check("io blocked", cmds[i] != NVSRS_CMD_NONE, ioBlocked);
         if (cmds[i] == NVSRS_CMD_NONE)
            continue;
         repeat (SOFT_SEQ_CYCLES + 2) @(negedge clock);
         check("store run", cmds[i] == NVSRS_CMD_STORE, nvStoreActive);
         check("recall run", cmds[i] == NVSRS_CMD_RECALL, nvRecallActive);
         wait_idle(ST_CYC + 8);
         if (cmds[i] == NVSRS_CMD_STORE || cmds[i] == NVSRS_CMD_RECALL)
            modelLatch = 0;
         if (cmds[i] == NVSRS_CMD_PLS_EN || cmds[i] == NVSRS_CMD_PLS_DIS)
            plsModel = (cmds[i] == NVSRS_CMD_PLS_EN);
         check("pls enable", plsModel[0], powerLossStoreEn);
         check("latch after", modelLatch[0], writeLatch);
         if (cmds[i] == NVSRS_CMD_PLS_DIS)
         begin
            // With the enable off a supply drop must not store
            arrayWriteReq = 1'b1;
            modelLatch = 1;
            poke(10, 1'b0);
            lowVoltageTrip = 1'b1;
            repeat (4) @(negedge clock);
            check("disabled store", 1'b0, nvStoreActive);
            poke(4, 1'b1);
            lowVoltageTrip = 1'b0;
            repeat (4) @(negedge clock);
         end
      end
      results();
   end
endmodule

// >>> src/nvsrs_pkg.sv
package nvsrs_pkg;

   // Clock rate in kHz (40 MHz)
   localparam int CLOCK_KHZ = 40000;

   // Timing figures in their own units
   localparam int RECALL_DURATION_US     = 600;
   localparam int SOFT_SEQUENCE_TIME_US  = 500;
   localparam int HW_STORE_PULSE_MIN_NS  = 15;
   localparam int STORE_DURATION_MS      = 8;
   localparam int ERRATA_GAP_LO_US       = 50;
   localparam int ERRATA_GAP_HI_US       = 280;

   // Cycle counts derived from the rate; longest times round down
   localparam int RECALL_CYCLES = RECALL_DURATION_US * CLOCK_KHZ / 1000;
   localparam int SOFT_SEQ_CYCLES = SOFT_SEQUENCE_TIME_US * CLOCK_KHZ / 1000;
   localparam int STORE_CYCLES = STORE_DURATION_MS * CLOCK_KHZ;
   localparam int HW_PULSE_CYCLES_RAW = (HW_STORE_PULSE_MIN_NS * CLOCK_KHZ + 999999) / 1000000;
   localparam int HW_PULSE_CYCLES = (HW_PULSE_CYCLES_RAW < 1) ? 1 : HW_PULSE_CYCLES_RAW;
   localparam int GAP_LO_CYCLES = ERRATA_GAP_LO_US * CLOCK_KHZ / 1000;
   localparam int GAP_HI_CYCLES = ERRATA_GAP_HI_US * CLOCK_KHZ / 1000;

   localparam int CNT_W = 20;

   // Soft sequence commands
   typedef enum logic [2:0] {
      NVSRS_CMD_NONE,
      NVSRS_CMD_STORE,
      NVSRS_CMD_RECALL,
      NVSRS_CMD_PLS_EN,
      NVSRS_CMD_PLS_DIS
   } nvsrs_cmd_t;

   typedef enum logic [2:0] {
      NVSRS_IDLE,
      NVSRS_CMDWAIT,
      NVSRS_STORE,
      NVSRS_RECALL
   } nvsrs_state_t;

endpackage

// >>> src/nvsrs_sequencer.sv
`timescale 1ns/10ps
module nvsrs_sequencer
#(
   parameter int STORE_CYCLES_P  = nvsrs_pkg::STORE_CYCLES,
   parameter int RECALL_CYCLES_P = nvsrs_pkg::RECALL_CYCLES
)
(
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire logic                 hwStoreBusyPinInN,
   input  wire logic                 lowVoltageTrip,
   input  wire logic                 fastSerialClock,
   input  wire logic                 cmdValid,
   input  wire nvsrs_pkg::nvsrs_cmd_t cmdCode,
   input  wire logic                 accessStart,
   input  wire logic                 arrayWriteReq,
   input  wire logic                 arrayReadReq,
   output logic                      arrayWriteEn,
   output logic                      arrayReadEn,
   output logic                      ioBlocked,
   output logic                      nvStoreActive,
   output logic                      nvRecallActive,
   output logic                      powerLossStoreEn,
   output logic                      writeLatch,
   output logic                      hwStoreBusyPinOut,
   output logic                      hwStoreBusyPinOe,
   output logic                      accessRisk
);
   import nvsrs_pkg::*;

   logic                rstMeta_q;
   logic                rstN_q;
   logic [1:0]          syncOut;
   logic                pinLowS;
   logic                lowVS;
   nvsrs_state_t        state_q;
   logic [CNT_W-1:0]    timer_q;
   logic [CNT_W-1:0]    gap_q;
   nvsrs_cmd_t          pendCmd_q;
   logic                pinPrev_q;
   logic                lowVPrev_q;
   logic                hwReq;
   logic                plReq;
   logic                arrayBlocked;
   logic [CNT_W-1:0]    cmdWaitCnt_q;

   // Reset release through two flip-flops
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end

   nvsrs_sync #(.WIDTH(2)) u_sync (
      .clock   (clock),
      .resetN  (rstN_q),
      .asyncIn ({~hwStoreBusyPinInN, lowVoltageTrip}),
      .syncOut (syncOut)
   );
   assign pinLowS = syncOut[1];
   assign lowVS   = syncOut[0];

   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         pinPrev_q  <= 1'b0;
         lowVPrev_q <= 1'b0;
      end
      else
      begin
         pinPrev_q  <= pinLowS;
         lowVPrev_q <= lowVS;
      end
   end

   // Pin low seen as a request edge
   assign hwReq = pinLowS && !pinPrev_q;
   assign plReq = lowVS && !lowVPrev_q && powerLossStoreEn;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction

   // Operation sequencer; power-up recall starts after reset
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         state_q   <= NVSRS_RECALL;
         timer_q   <= cyc(RECALL_CYCLES_P);
         pendCmd_q <= NVSRS_CMD_NONE;
      end
      else
      begin
         unique case (state_q)
            NVSRS_IDLE:
            begin
               if ((plReq || hwReq) && writeLatch)
               begin
                  state_q <= NVSRS_STORE;
                  timer_q <= cyc(STORE_CYCLES_P);
               end
               else if (cmdValid && cmdCode != NVSRS_CMD_NONE && !lowVS)
               begin
                  state_q   <= NVSRS_CMDWAIT;
                  pendCmd_q <= cmdCode;
                  timer_q   <= cyc(SOFT_SEQ_CYCLES);
               end
            end
            NVSRS_CMDWAIT:
            begin
               // Command acted on within soft sequence time
               if (timer_q == '0)
               begin
                  pendCmd_q <= NVSRS_CMD_NONE;
                  if (pendCmd_q == NVSRS_CMD_STORE)
                  begin
                     state_q <= NVSRS_STORE;
                     timer_q <= cyc(STORE_CYCLES_P);
                  end
                  else if (pendCmd_q == NVSRS_CMD_RECALL)
                  begin
                     state_q <= NVSRS_RECALL;
                     timer_q <= cyc(RECALL_CYCLES_P);
                  end
                  else
                     state_q <= NVSRS_IDLE;
               end
               else
                  timer_q <= timer_q - 1'b1;
            end
            NVSRS_STORE,
            NVSRS_RECALL:
            begin
               if (timer_q == '0)
                  state_q <= NVSRS_IDLE;
               else
                  timer_q <= timer_q - 1'b1;
            end
            default:
               state_q <= NVSRS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
         cmdWaitCnt_q <= '0;
      else if (state_q == NVSRS_CMDWAIT)
         cmdWaitCnt_q <= cmdWaitCnt_q + 1'b1;
      else
         cmdWaitCnt_q <= '0;
   end

   // Power-loss store enable follows the soft commands
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
         powerLossStoreEn <= 1'b1;
      else if (state_q == NVSRS_CMDWAIT && timer_q == '0)
      begin
         if (pendCmd_q == NVSRS_CMD_PLS_EN)
            powerLossStoreEn <= 1'b1;
         else if (pendCmd_q == NVSRS_CMD_PLS_DIS)
            powerLossStoreEn <= 1'b0;
      end
   end

   // Write latch: a write wins over the clear at a nonvolatile end
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
         writeLatch <= 1'b0;
      else if (arrayWriteEn)
         writeLatch <= 1'b1;
      else if ((state_q == NVSRS_STORE || state_q == NVSRS_RECALL) && timer_q == '0)
         writeLatch <= 1'b0;
   end

   // Array gated by operations, brownout and pin
   assign arrayBlocked = (state_q == NVSRS_STORE) || (state_q == NVSRS_RECALL) || lowVS || pinLowS;
   assign arrayWriteEn = arrayWriteReq && !arrayBlocked && !ioBlocked;
   assign arrayReadEn  = arrayReadReq && !arrayBlocked && !ioBlocked;

   // Serial I/O locked out during commanded operations
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         ioBlocked      <= 1'b1;
         nvStoreActive  <= 1'b0;
         nvRecallActive <= 1'b1;
      end
      else
      begin
         ioBlocked      <= (state_q != NVSRS_IDLE);
         nvStoreActive  <= (state_q == NVSRS_STORE);
         nvRecallActive <= (state_q == NVSRS_RECALL);
      end
   end

   // Device pulls its busy pin low during any store
   assign hwStoreBusyPinOut = 1'b0;
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
         hwStoreBusyPinOe <= 1'b0;
      else
         hwStoreBusyPinOe <= (state_q == NVSRS_STORE);
   end

   // Gap counter between accesses for the fast-clock hazard
   always_ff @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         gap_q      <= '1;
         accessRisk <= 1'b0;
      end
      else
      begin
         if (accessStart)
         begin
            accessRisk <= fastSerialClock && gap_q >= CNT_W'(GAP_LO_CYCLES) && gap_q <= CNT_W'(GAP_HI_CYCLES);
            gap_q      <= '0;
         end
         else if (gap_q != '1)
            gap_q <= gap_q + 1'b1;
      end
   end

   no_write_busy_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (state_q != NVSRS_IDLE && state_q != NVSRS_CMDWAIT) |-> !arrayWriteEn)
      else $error("array write while busy");

   pin_blocks_a: assert property (@(posedge clock) disable iff (!rstN_q)
      pinLowS |-> !arrayReadEn && !arrayWriteEn)
      else $error("array open while pin low");

   skip_store_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (state_q == NVSRS_IDLE && hwReq && !writeLatch && !cmdValid) |=> state_q == NVSRS_IDLE)
      else $error("store started with no pending write");

   io_lock_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (state_q == NVSRS_RECALL) |=> ioBlocked)
      else $error("io not blocked during recall");

   cmd_start_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (state_q == NVSRS_CMDWAIT) |-> cmdWaitCnt_q < CNT_W'(SOFT_SEQ_CYCLES))
      else $error("soft command wait too long");

   recall_len_a: assert property (@(posedge clock) disable iff (!rstN_q)
      $rose(state_q == NVSRS_RECALL) |-> timer_q == cyc(RECALL_CYCLES_P))
      else $error("recall length wrong");

   hw_store_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (state_q == NVSRS_IDLE && hwReq && writeLatch) |=> state_q == NVSRS_STORE)
      else $error("pin store not started");

   risk_flag_a: assert property (@(posedge clock) disable iff (!rstN_q)
      (accessStart && !fastSerialClock) |=> !accessRisk)
      else $error("risk flagged at slow clock");
endmodule

// >>> src/nvsrs_sync.sv
`timescale 1ns/10ps
module nvsrs_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clock,
   input  wire logic             resetN,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clock or negedge resetN)
   begin
      if (!resetN)
      begin
         meta_q  <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule
